// ===== hw/fine_gain_control_regs.sv
// Purpose: Fine transmit and receive gain registers and the 0.1 dB step scaler they steer.
// Assumes: Register strobes come decoded from the serial control port, synchronous to sys_clk_in.
// Notes:   Each path scales one 16-bit signed sample per valid strobe, one cycle of latency.
//
// Summary of operation
// - Transmit direction clear: larger transmit magnitude gives more transmit gain.
// - Transmit direction set: larger transmit magnitude gives deeper transmit attenuation.
// - Transmit magnitude zero leaves the transmit path at 0 dB, any direction.
// - Transmit magnitude in bits 3:0, 0.1 dB per step; code one gives 0.1 dB.
// - Transmit direction clear, code fifteen gives 1.5 dB gain, the maximum.
// - Transmit direction set: code one attenuates 0.1 dB, code fifteen 1.5 dB.
// - Receive direction clear: larger receive magnitude gives more receive gain.
// - Receive direction set: larger receive magnitude gives deeper receive attenuation.
// - Receive magnitude zero leaves the receive path at 0 dB, any direction.
// - Receive magnitude in bits 3:0, 0.1 dB per step; code one gives 0.1 dB.
// - Receive direction clear, code fifteen gives 1.5 dB gain.
// - Receive direction set: code one attenuates 0.1 dB, code fifteen 1.5 dB.
`timescale 1ns/1ps
`include "fine_gain_params.svh"

module fine_gain_control_regs #(
  parameter int SAMPLE_WIDTH = 16
) (
  input  wire logic                            sys_clk_in,
  input  wire logic                            reset_n_in,
  input  wire logic                            reg_wr_en_in,
  input  wire logic                            reg_rd_en_in,
  input  wire logic [7:0]                      reg_addr_in,
  input  wire logic [7:0]                      reg_wdata_in,
  output logic      [7:0]                      reg_rdata_out,
  output logic                                 reg_rvalid_out,
  input  wire logic                            tx_sample_valid_in,
  input  wire logic signed [SAMPLE_WIDTH-1:0]  tx_sample_in,
  output logic                                 tx_sample_valid_out,
  output logic signed [SAMPLE_WIDTH-1:0]       tx_sample_out,
  input  wire logic                            rx_sample_valid_in,
  input  wire logic signed [SAMPLE_WIDTH-1:0]  rx_sample_in,
  output logic                                 rx_sample_valid_out,
  output logic signed [SAMPLE_WIDTH-1:0]       rx_sample_out
);

  // ========================================================================
  // Coefficient lookup
  // Gain and attenuation are exact reciprocals of 10^(k/200) in Q2.14, so a
  // gain step and the matching attenuation step cancel to within one LSB.
  function automatic fine_gain_pkg::coef_type coef_of(input logic dir,
                                                      input fine_gain_pkg::magnitude_type mag);
    fine_gain_pkg::coef_type c;
    c = 16'h4000;
    case ({dir, mag})
      5'h01: c = 16'h40be;
      5'h02: c = 16'h417e;
      5'h03: c = 16'h4240;
      5'h04: c = 16'h4304;
      5'h05: c = 16'h43cb;
      5'h06: c = 16'h4494;
      5'h07: c = 16'h455f;
      5'h08: c = 16'h462d;
      5'h09: c = 16'h46fd;
      5'h0a: c = 16'h47cf;
      5'h0b: c = 16'h48a4;
      5'h0c: c = 16'h497b;
      5'h0d: c = 16'h4a55;
      5'h0e: c = 16'h4b31;
      5'h0f: c = 16'h4c10;
      5'h11: c = 16'h3f45;
      5'h12: c = 16'h3e8b;
      5'h13: c = 16'h3dd4;
      5'h14: c = 16'h3d1f;
      5'h15: c = 16'h3c6c;
      5'h16: c = 16'h3bba;
      5'h17: c = 16'h3b0c;
      5'h18: c = 16'h3a5e;
      5'h19: c = 16'h39b3;
      5'h1a: c = 16'h390a;
      5'h1b: c = 16'h3863;
      5'h1c: c = 16'h37be;
      5'h1d: c = 16'h371a;
      5'h1e: c = 16'h3679;
      5'h1f: c = 16'h35d9;
      default: c = 16'h4000;
    endcase
    return c;
  endfunction : coef_of

  // ========================================================================
  // Register file
  logic [7:0] tx_fine_gain_r;
  logic [7:0] rx_fine_gain_r;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_fine_gain_r <= `TX_FINE_GAIN_RESET;
      rx_fine_gain_r <= `RX_FINE_GAIN_RESET;
    end else if (reg_wr_en_in) begin
      // Reserved bits 7:5 are masked to zero on write, so they always read back as zero.
      if (reg_addr_in == `TX_FINE_GAIN_OFFSET) begin
        tx_fine_gain_r <= reg_wdata_in & `FINE_WRITABLE_MASK;
      end
      if (reg_addr_in == `RX_FINE_GAIN_OFFSET) begin
        rx_fine_gain_r <= reg_wdata_in & `FINE_WRITABLE_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_en_in;
      if (reg_rd_en_in) begin
        case (reg_addr_in)
          `TX_FINE_GAIN_OFFSET: reg_rdata_out <= tx_fine_gain_r;
          `RX_FINE_GAIN_OFFSET: reg_rdata_out <= rx_fine_gain_r;
          default:              reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // ========================================================================
  // Sample scalers, index 0 is transmit and index 1 is receive
  logic                           valid_in_w  [2];
  logic signed [SAMPLE_WIDTH-1:0] sample_in_w [2];
  logic [7:0]                     setting_w   [2];
  logic                           valid_r     [2];
  logic signed [SAMPLE_WIDTH-1:0] sample_r    [2];

  assign valid_in_w[0]  = tx_sample_valid_in;
  assign valid_in_w[1]  = rx_sample_valid_in;
  assign sample_in_w[0] = tx_sample_in;
  assign sample_in_w[1] = rx_sample_in;
  assign setting_w[0]   = tx_fine_gain_r;
  assign setting_w[1]   = rx_fine_gain_r;

  assign tx_sample_valid_out = valid_r[0];
  assign tx_sample_out       = sample_r[0];
  assign rx_sample_valid_out = valid_r[1];
  assign rx_sample_out       = sample_r[1];

  localparam logic signed [SAMPLE_WIDTH+2:0] SAT_MAX = (SAMPLE_WIDTH+3)'((1 <<< (SAMPLE_WIDTH-1)) - 1);
  localparam logic signed [SAMPLE_WIDTH+2:0] SAT_MIN = -(SAMPLE_WIDTH+3)'(1 <<< (SAMPLE_WIDTH-1));

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_path
      fine_gain_pkg::coef_type          coef_w;
      logic signed [SAMPLE_WIDTH+16:0]  product_w;
      logic signed [SAMPLE_WIDTH+2:0]   scaled_w;
      logic                             dir_w;
      fine_gain_pkg::magnitude_type     mag_w;

      // The coefficient is read in the cycle that accepts a sample, so a register
      // write only reaches samples accepted after it.
      assign dir_w     = setting_w[p][`FINE_DIRECTION_BIT];
      assign mag_w     = setting_w[p][`FINE_MAGNITUDE_MSB:`FINE_MAGNITUDE_LSB];
      assign coef_w    = coef_of(dir_w, mag_w);
      assign product_w = sample_in_w[p] * $signed({1'b0, coef_w}) + (SAMPLE_WIDTH+17)'(`COEF_ROUND);
      assign scaled_w  = (SAMPLE_WIDTH+3)'(product_w >>> `COEF_FRAC_BITS);

      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          valid_r[p]  <= 1'b0;
          sample_r[p] <= '0;
        end else begin
          valid_r[p] <= valid_in_w[p];
          if (valid_in_w[p]) begin
            // Gain above unity can overflow full scale, so clip rather than wrap.
            if (scaled_w > SAT_MAX) begin
              sample_r[p] <= SAT_MAX[SAMPLE_WIDTH-1:0];
            end else if (scaled_w < SAT_MIN) begin
              sample_r[p] <= SAT_MIN[SAMPLE_WIDTH-1:0];
            end else begin
              sample_r[p] <= scaled_w[SAMPLE_WIDTH-1:0];
            end
          end
        end
      end

      // ====================================================================
      // Checks
      // Latency and hold are checked apart from the arithmetic, so a pipeline slip
      // shows up as its own failure instead of as a wrong sample value.
      latency_one_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] |=> valid_r[p])
        else $error("Scaled sample not delivered one cycle after acceptance.");

      hold_idle_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !valid_in_w[p] |=> !valid_r[p] && $stable(sample_r[p]))
        else $error("Output changed without an accepted sample.");

      unity_coef_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        mag_w == 4'h0 |-> coef_w == 16'h4000)
        else $error("Magnitude zero did not select the unity coefficient.");

      zero_is_unity_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && mag_w == 4'h0
          |=> sample_r[p] == $past(sample_in_w[p]))
        else $error("Magnitude zero altered the sample.");

      // Every code step must move the coefficient the way the direction bit asks,
      // which a single swapped table entry would break.
      steps_monotone_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        mag_w != 4'h0
          |-> (dir_w ? coef_w < coef_of(dir_w, mag_w - 4'h1)
                     : coef_w > coef_of(dir_w, mag_w - 4'h1)))
        else $error("Coefficient did not follow the magnitude code.");

      gain_raises_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && !dir_w && mag_w != 4'h0 && sample_in_w[p] > 16'sh1000
          && sample_in_w[p] < 16'sh6000 |=> sample_r[p] > $past(sample_in_w[p]))
        else $error("Gain setting did not raise the sample.");

      atten_lowers_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && dir_w && mag_w != 4'h0 && sample_in_w[p] > 16'sh1000
          |=> sample_r[p] < $past(sample_in_w[p]))
        else $error("Attenuation setting did not lower the sample.");

      // Rounding must never pull a nonzero sample across the axis, nor a negative one up to zero.
      sign_kept_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && sample_in_w[p] != '0
          |=> (sample_r[p] < 0) == ($past(sample_in_w[p]) < 0))
        else $error("Scaling changed the sign of a sample.");

      step_one_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && {dir_w, mag_w} == 5'h01 && sample_in_w[p] == 16'sh4000
          |=> sample_r[p] == 16'sh40be)
        else $error("Code one gain is not 0.1 dB.");

      max_gain_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && {dir_w, mag_w} == 5'h0f && sample_in_w[p] == 16'sh4000
          |=> sample_r[p] == 16'sh4c10)
        else $error("Code fifteen gain is not 1.5 dB.");

      // Full-scale inputs under gain must stop at the rails instead of wrapping.
      clip_high_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && !dir_w && mag_w != 4'h0 && sample_in_w[p] == 16'sh7fff
          |=> sample_r[p] == 16'sh7fff)
        else $error("Positive full scale under gain did not clip.");

      clip_low_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && !dir_w && mag_w != 4'h0 && sample_in_w[p] == 16'sh8000
          |=> sample_r[p] == 16'sh8000)
        else $error("Negative full scale under gain did not clip.");

      atten_ends_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && dir_w && sample_in_w[p] == 16'sh4000
          && (mag_w == 4'h1 || mag_w == 4'hf)
          |=> sample_r[p] == ($past(mag_w) == 4'h1 ? 16'sh3f45 : 16'sh35d9))
        else $error("Attenuation end points are wrong.");

      gain_cover_c  : cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && !dir_w && mag_w == 4'hf);
      atten_cover_c : cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        valid_in_w[p] && dir_w && mag_w == 4'hf);
    end
  endgenerate

  // ========================================================================
  // Register checks
  write_lands_tx_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_wr_en_in && reg_addr_in == `TX_FINE_GAIN_OFFSET
      |=> tx_fine_gain_r == ($past(reg_wdata_in) & `FINE_WRITABLE_MASK))
    else $error("Transmit write did not land.");

  write_lands_rx_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_wr_en_in && reg_addr_in == `RX_FINE_GAIN_OFFSET
      |=> rx_fine_gain_r == ($past(reg_wdata_in) & `FINE_WRITABLE_MASK))
    else $error("Receive write did not land.");

  // Only a write to one of the two offsets may move a setting, so a sample in
  // flight never meets a stray change.
  setting_hold_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !(reg_wr_en_in && (reg_addr_in == `TX_FINE_GAIN_OFFSET || reg_addr_in == `RX_FINE_GAIN_OFFSET))
      |=> $stable(tx_fine_gain_r) && $stable(rx_fine_gain_r))
    else $error("A setting changed without a write to it.");

  readback_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_wr_en_in && reg_addr_in == `TX_FINE_GAIN_OFFSET ##1 reg_rd_en_in && !reg_wr_en_in
      && reg_addr_in == `TX_FINE_GAIN_OFFSET |=> reg_rdata_out == ($past(reg_wdata_in, 2) & `FINE_WRITABLE_MASK))
    else $error("Transmit register readback mismatch.");

  unmapped_read_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_rd_en_in && reg_addr_in != `TX_FINE_GAIN_OFFSET && reg_addr_in != `RX_FINE_GAIN_OFFSET
      |=> reg_rdata_out == 8'h00)
    else $error("Unmapped address did not read zero.");

  reserved_zero_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_rvalid_out |-> (reg_rdata_out & ~`FINE_WRITABLE_MASK) == 8'h00)
    else $error("Reserved bits did not read zero.");

  // Read data is registered and held, so the host may take it any time before
  // its next read strobe.
  read_valid_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_rd_en_in |=> reg_rvalid_out)
    else $error("Read valid missing one cycle after the read strobe.");

  read_hold_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !reg_rd_en_in |=> !reg_rvalid_out && $stable(reg_rdata_out))
    else $error("Read data moved without a read strobe.");

  write_during_sample_c : cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_wr_en_in && tx_sample_valid_in);

  readback_cover_c : cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reg_wr_en_in && reg_addr_in == `TX_FINE_GAIN_OFFSET ##1 reg_rd_en_in && reg_addr_in == `TX_FINE_GAIN_OFFSET);

endmodule : fine_gain_control_regs

// ===== inc/fine_gain_params.svh
// Purpose: Offsets, field positions, reset values and scaling constants of the fine gain registers.
// Assumes: Included by its bare name from the design and testbench files.
// Notes:   Definitions only.
`ifndef FINE_GAIN_PARAMS_SVH
`define FINE_GAIN_PARAMS_SVH

// ==========================================================================
// Register offsets
`define TX_FINE_GAIN_OFFSET   8'h28
`define RX_FINE_GAIN_OFFSET   8'h29

// ==========================================================================
// Field layout
`define FINE_DIRECTION_BIT    4
`define FINE_MAGNITUDE_MSB    3
`define FINE_MAGNITUDE_LSB    0
`define FINE_WRITABLE_MASK    8'h1f

// ==========================================================================
// Reset values
`define TX_FINE_GAIN_RESET    8'h00
`define RX_FINE_GAIN_RESET    8'h00

// ==========================================================================
// Coefficient scaling: unity is 2 to the power of the shift.
`define COEF_FRAC_BITS        14
`define COEF_ROUND            33'sh0_0000_2000

`endif

// ===== inc/fine_gain_pkg.sv
// Purpose: Shared types of the fine gain control block.
// Assumes: Constants live in fine_gain_params.svh.
// Notes:   Nothing here is imported; users write fine_gain_pkg::name.
package fine_gain_pkg;

  // ========================================================================
  // Types
  typedef logic        [7:0]  reg_byte_type;
  typedef logic        [3:0]  magnitude_type;
  typedef logic        [15:0] coef_type;
  typedef logic signed [15:0] sample_type;

endpackage : fine_gain_pkg

// ===== testbench/fine_gain_control_regs_tb.sv
// Purpose: Self-checking bench for the fine transmit and receive gain registers and their sample scaler.
// Assumes: Register strobes and sample strobes are driven per clock at the rising clock edge, and may stay high for several clocks.
// Notes:   Expected samples come from the coefficient tables below with round half up and saturation.
`timescale 1ns/1ps
`include "fine_gain_params.svh"

module fine_gain_control_regs_tb;

  // ==========================================================================
  // Signals and reference state
  logic                      sys_clk_in, reset_n_in, reg_wr_en_in, reg_rd_en_in, reg_rvalid_out;
  logic                      tx_sample_valid_in, tx_sample_valid_out, rx_sample_valid_in, rx_sample_valid_out;
  logic [7:0]                reg_addr_in, reg_wdata_in, reg_rdata_out, tx_set, rx_set, rd_exp;
  fine_gain_pkg::sample_type tx_sample_in, tx_sample_out, rx_sample_in, rx_sample_out;
  logic [15:0]               tx_exp, rx_exp, smp;
  logic                      tx_pend, rx_pend, rd_pend;
  int                        failures, n_tests;
  fine_gain_pkg::coef_type   gain_tab [16] = '{16'h4000, 16'h40be, 16'h417e, 16'h4240, 16'h4304, 16'h43cb,
    16'h4494, 16'h455f, 16'h462d, 16'h46fd, 16'h47cf, 16'h48a4, 16'h497b, 16'h4a55, 16'h4b31, 16'h4c10};
  fine_gain_pkg::coef_type   att_tab [16] = '{16'h4000, 16'h3f45, 16'h3e8b, 16'h3dd4, 16'h3d1f, 16'h3c6c,
    16'h3bba, 16'h3b0c, 16'h3a5e, 16'h39b3, 16'h390a, 16'h3863, 16'h37be, 16'h371a, 16'h3679, 16'h35d9};
  fine_gain_pkg::sample_type corner [4] = '{16'h4000, 16'h7fff, 16'h8000, 16'hc001};

  fine_gain_control_regs i_dut (
    .sys_clk_in          (sys_clk_in),
    .reset_n_in          (reset_n_in),
    .reg_wr_en_in        (reg_wr_en_in),
    .reg_rd_en_in        (reg_rd_en_in),
    .reg_addr_in         (reg_addr_in),
    .reg_wdata_in        (reg_wdata_in),
    .reg_rdata_out       (reg_rdata_out),
    .reg_rvalid_out      (reg_rvalid_out),
    .tx_sample_valid_in  (tx_sample_valid_in),
    .tx_sample_in        (tx_sample_in),
    .tx_sample_valid_out (tx_sample_valid_out),
    .tx_sample_out       (tx_sample_out),
    .rx_sample_valid_in  (rx_sample_valid_in),
    .rx_sample_in        (rx_sample_in),
    .rx_sample_valid_out (rx_sample_valid_out),
    .rx_sample_out       (rx_sample_out)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // ==========================================================================
  // Reference arithmetic and checking
  function automatic logic [15:0] scale(input logic [7:0] setv, input logic [15:0] s);
    logic signed [32:0] p;
    logic [15:0]        c;
    c = setv[4] ? att_tab[setv[3:0]] : gain_tab[setv[3:0]];
    p = $signed(s) * $signed({1'b0, c});
    p = (p + 33'sd8192) >>> 14;
    if (p > 33'sd32767) return 16'h7fff;
    if (p < -33'sd32768) return 16'h8000;
    return p[15:0];
  endfunction : scale

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // One clock of stimulus; outputs of the previous clock's requests are compared after this edge.
  task automatic step(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] wd,
                      input logic tv, input logic [15:0] ts, input logic rv, input logic [15:0] rs);
    logic [15:0] te, re;
    logic [7:0]  rde;
    te  = tv ? scale(tx_set, ts) : tx_exp;
    re  = rv ? scale(rx_set, rs) : rx_exp;
    rde = !rd ? rd_exp : (addr == `TX_FINE_GAIN_OFFSET) ? tx_set : (addr == `RX_FINE_GAIN_OFFSET) ? rx_set : 8'h00;
    @(posedge sys_clk_in);
    reg_wr_en_in       <= wr;
    reg_rd_en_in       <= rd;
    reg_addr_in        <= addr;
    reg_wdata_in       <= wd;
    tx_sample_valid_in <= tv;
    tx_sample_in       <= ts;
    rx_sample_valid_in <= rv;
    rx_sample_in       <= rs;
    if (wr && addr == `TX_FINE_GAIN_OFFSET) tx_set = wd & 8'h1f;
    if (wr && addr == `RX_FINE_GAIN_OFFSET) rx_set = wd & 8'h1f;
    #1;
    check({15'h0000, tx_sample_valid_out}, {15'h0000, tx_pend});
    check(tx_sample_out, tx_exp);
    check({15'h0000, rx_sample_valid_out}, {15'h0000, rx_pend});
    check(rx_sample_out, rx_exp);
    check({15'h0000, reg_rvalid_out}, {15'h0000, rd_pend});
    check({8'h00, reg_rdata_out}, {8'h00, rd_exp});
    tx_pend = tv;
    tx_exp  = te;
    rx_pend = rv;
    rx_exp  = re;
    rd_pend = rd;
    rd_exp  = rde;
  endtask : step

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(30744));
    {reset_n_in, reg_wr_en_in, reg_rd_en_in, tx_sample_valid_in, rx_sample_valid_in} = 5'h00;
    {reg_addr_in, reg_wdata_in, tx_sample_in, rx_sample_in} = 48'h0;
    {tx_set, rx_set, rd_exp, tx_exp, rx_exp} = 56'h0;
    {tx_pend, rx_pend, rd_pend} = 3'h0;
    failures = 0;
    n_tests  = 0;
    repeat (10) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    step(1'b0, 1'b1, `TX_FINE_GAIN_OFFSET, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
    step(1'b0, 1'b1, `RX_FINE_GAIN_OFFSET, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
    step(1'b0, 1'b1, 8'h2a, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
    // Every direction and magnitude on both paths; the receive path runs the mirrored code.
    for (int d = 0; d < 2; d++) begin
      for (int m = 0; m < 16; m++) begin
        step(1'b1, 1'b1, `RX_FINE_GAIN_OFFSET, {3'($urandom), 1'(~d), 4'(15 - m)}, 1'b0, 16'h0000, 1'b0, 16'h0000);
        step(1'b1, 1'b0, `TX_FINE_GAIN_OFFSET, {3'($urandom), 1'(d), 4'(m)}, 1'b0, 16'h0000, 1'b0, 16'h0000);
        step(1'b0, 1'b1, `TX_FINE_GAIN_OFFSET, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
        for (int k = 0; k < 8; k++) begin
          smp = (k < 4) ? corner[k] : 16'($urandom);
          step(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, smp, 1'b1, ~smp);
        end
      end
    end
    // A write landing with a sample must leave that sample on the old setting.
    step(1'b1, 1'b0, `TX_FINE_GAIN_OFFSET, 8'h0f, 1'b1, 16'h4000, 1'b1, 16'h4000);
    step(1'b1, 1'b0, `RX_FINE_GAIN_OFFSET, 8'h0f, 1'b1, 16'h4000, 1'b1, 16'h4000);
    step(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 16'h4000, 1'b1, 16'h4000);
    step(1'b1, 1'b0, 8'h2a, 8'hff, 1'b0, 16'h0000, 1'b0, 16'h0000);
    step(1'b0, 1'b1, 8'h2a, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
    step(1'b0, 1'b1, `TX_FINE_GAIN_OFFSET, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
    step(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
    stop_test();
  end

  // The sequence needs well under 1000 clocks; the limit leaves a wide margin.
  initial begin
    #50000;
    failures++;
    stop_test();
  end

endmodule : fine_gain_control_regs_tb
